// [rdi_cfg.svh]
`ifndef RDI_CFG_SVH
`define RDI_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RDI_ADDR_COMM_EN   8'h02
`define RDI_ADDR_AUX_EN    8'h03
`define RDI_ADDR_COMM_REQ  8'h04
`define RDI_ADDR_AUX_REQ   8'h05
`define RDI_ADDR_ERR       8'h06

// ****************************************************************
// Reset values
// ****************************************************************
`define RDI_RST_COMM_EN    8'h80
`define RDI_RST_AUX_EN     8'h00
`define RDI_RST_COMM_REQ   8'h14
`define RDI_RST_AUX_REQ    8'h00
`define RDI_RST_ERR        8'h00
`define RDI_RST_BYTE       8'h00
`define RDI_RST_BIT        1'b0

// ****************************************************************
// Writable and readable bit masks
// ****************************************************************
`define RDI_MASK_COMM_EN   8'hFF
`define RDI_MASK_AUX_EN    8'hB4
`define RDI_MASK_COMM_REQ  8'h7F
`define RDI_MASK_AUX_REQ   8'h34

// ****************************************************************
// Field positions
// ****************************************************************
`define RDI_BIT_SETSEL     7
`define RDI_BIT_INVERT     7
`define RDI_BIT_DRIVE      7
`define RDI_BIT_TX         6
`define RDI_BIT_RX         5
`define RDI_BIT_IDLE       4
`define RDI_BIT_HI         3
`define RDI_BIT_LO         2
`define RDI_BIT_ERRF       1
`define RDI_BIT_TIMER      0
`define RDI_BIT_CARD       5
`define RDI_BIT_TEST       4
`define RDI_BIT_CRCD       2
`define RDI_BIT_E_WR       7
`define RDI_BIT_E_TEMP     6
`define RDI_BIT_E_OVFL     4
`define RDI_BIT_E_COLL     3
`define RDI_BIT_E_CRC      2
`define RDI_BIT_E_PAR      1
`define RDI_BIT_E_SOF      0

// ****************************************************************
// Misc values
// ****************************************************************
`define RDI_TIMER_ZERO     16'h0000

`endif

// [rdi_pkg.sv]
package rdi_pkg;

    // ************************************************************
    // Core register state
    // ************************************************************
    typedef struct packed {
        logic [7:0] comm_en;
        logic [7:0] aux_en;
        logic [7:0] comm_req;
        logic [7:0] aux_req;
        logic [7:0] err;
        logic [7:0] rdata;
        logic       cmd_clear;
    } rdi_core_t;

    // ************************************************************
    // Event detector state
    // ************************************************************
    typedef struct packed {
        logic hi_prev;
        logic lo_prev;
        logic test_prev;
        logic timer_nonzero;
    } rdi_det_t;

endpackage

// [rdi_evt_if.sv]
interface rdi_evt_if #(
    parameter int TW = 16
);
    logic          fifo_high_status;
    logic          fifo_low_status;
    logic          test_signal_input;
    logic [TW-1:0] timer_current_value;
    logic          hi_rise;
    logic          lo_rise;
    logic          test_edge;
    logic          timer_zero;

    modport det (
        input  fifo_high_status,
        input  fifo_low_status,
        input  test_signal_input,
        input  timer_current_value,
        output hi_rise,
        output lo_rise,
        output test_edge,
        output timer_zero
    );

    modport core (
        output fifo_high_status,
        output fifo_low_status,
        output test_signal_input,
        output timer_current_value,
        input  hi_rise,
        input  lo_rise,
        input  test_edge,
        input  timer_zero
    );
endinterface

// [rdi_evt_detect.sv]
`include "rdi_cfg.svh"

module rdi_evt_detect (
    input  wire logic clock,
    input  wire logic nrst,
    rdi_evt_if.det    ev
);

    rdi_pkg::rdi_det_t st_r;
    rdi_pkg::rdi_det_t st_nxt;

    // ************************************************************
    // Edge and terminal count detection
    // ************************************************************
    assign ev.hi_rise    = ev.fifo_high_status & ~st_r.hi_prev;
    assign ev.lo_rise    = ev.fifo_low_status & ~st_r.lo_prev;
    assign ev.test_edge  = ev.test_signal_input ^ st_r.test_prev;
    assign ev.timer_zero = st_r.timer_nonzero &
                           (ev.timer_current_value == `RDI_TIMER_ZERO);

    always_comb begin
        st_nxt               = st_r;
        st_nxt.hi_prev       = ev.fifo_high_status;
        st_nxt.lo_prev       = ev.fifo_low_status;
        st_nxt.test_prev     = ev.test_signal_input;
        st_nxt.timer_nonzero = (ev.timer_current_value != `RDI_TIMER_ZERO);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_r <= '{hi_prev: `RDI_RST_BIT, lo_prev: `RDI_RST_BIT,
                      test_prev: `RDI_RST_BIT, timer_nonzero: `RDI_RST_BIT};
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// [rdi_irq_flags.sv]
`include "rdi_cfg.svh"

module rdi_irq_flags #(
    parameter int TW = 16
) (
    input  wire logic          clock,
    input  wire logic          nrst,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [7:0]    reg_rdata,
    input  wire logic          tx_last_bit_sent,
    input  wire logic          rx_data_valid,
    input  wire logic          rx_require_no_error,
    input  wire logic          cmd_terminated,
    input  wire logic          cmd_unknown_started,
    input  wire logic          cmd_idle_started,
    input  wire logic          cmd_start,
    input  wire logic          fifo_high_status,
    input  wire logic          fifo_low_status,
    input  wire logic [TW-1:0] timer_current_value,
    input  wire logic          lpcd_card_detected,
    input  wire logic          test_signal_input,
    input  wire logic          crc_cmd_valid,
    input  wire logic          crc_all_done,
    input  wire logic          rx_startup,
    input  wire logic          rx_crc_check_enable,
    input  wire logic          crc_mismatch,
    input  wire logic          parity_fault,
    input  wire logic          sof_fault,
    input  wire logic          collision_fault,
    input  wire logic          rate_106k,
    input  wire logic          type_a_mode,
    input  wire logic          write_fault,
    input  wire logic          over_temp,
    input  wire logic          temp_clear,
    input  wire logic          fifo_overflow,
    input  wire logic          fifo_flush,
    output logic               irq_out,
    output logic               irq_oe,
    output logic               irq_status,
    output logic               cmd_field_clear
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] sc_write(
        input logic [7:0] cur,
        input logic [7:0] wd,
        input logic [7:0] mask,
        input logic       hit
    );
        logic [7:0] res;
        res = cur;
        if (hit) begin
            if (wd[`RDI_BIT_SETSEL]) begin
                res = cur | (wd & mask);
            end else begin
                res = cur & ~(wd & mask);
            end
        end
        return res;
    endfunction

    function automatic logic [7:0] put_bit(
        input logic [7:0] v,
        input int         pos,
        input logic       b
    );
        logic [7:0] res;
        res      = v;
        res[pos] = b;
        return res;
    endfunction

    // ************************************************************
    // State and event wiring
    // ************************************************************
    rdi_pkg::rdi_core_t st_r;
    rdi_pkg::rdi_core_t st_nxt;

    rdi_evt_if #(.TW(TW)) ev ();

    logic [7:0] comm_hw;
    logic [7:0] aux_hw;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic [7:0] err_next_v;
    logic       hit_comm_en;
    logic       hit_aux_en;
    logic       hit_comm_req;
    logic       hit_aux_req;
    logic       pin_level;

    assign ev.fifo_high_status    = fifo_high_status;
    assign ev.fifo_low_status     = fifo_low_status;
    assign ev.test_signal_input   = test_signal_input;
    assign ev.timer_current_value = timer_current_value;

    rdi_evt_detect u_det (
        .clock (clock),
        .nrst  (nrst),
        .ev    (ev.det)
    );

    assign hit_comm_en  = reg_wr && (reg_addr == `RDI_ADDR_COMM_EN);
    assign hit_aux_en   = reg_wr && (reg_addr == `RDI_ADDR_AUX_EN);
    assign hit_comm_req = reg_wr && (reg_addr == `RDI_ADDR_COMM_REQ);
    assign hit_aux_req  = reg_wr && (reg_addr == `RDI_ADDR_AUX_REQ);

    // ************************************************************
    // Error register events
    // ************************************************************
    always_comb begin
        err_set = `RDI_RST_BYTE;
        err_clr = `RDI_RST_BYTE;
        err_set = put_bit(err_set, `RDI_BIT_E_WR, write_fault);
        err_set = put_bit(err_set, `RDI_BIT_E_TEMP, over_temp);
        err_set = put_bit(err_set, `RDI_BIT_E_OVFL, fifo_overflow);
        err_set = put_bit(err_set, `RDI_BIT_E_COLL,
                          collision_fault & rate_106k);
        err_set = put_bit(err_set, `RDI_BIT_E_CRC,
                          crc_mismatch & rx_crc_check_enable);
        err_set = put_bit(err_set, `RDI_BIT_E_PAR,
                          parity_fault & rate_106k & type_a_mode);
        err_set = put_bit(err_set, `RDI_BIT_E_SOF,
                          sof_fault & rate_106k);
        err_clr = put_bit(err_clr, `RDI_BIT_E_WR, cmd_start);
        err_clr = put_bit(err_clr, `RDI_BIT_E_TEMP, temp_clear);
        err_clr = put_bit(err_clr, `RDI_BIT_E_OVFL, fifo_flush);
        err_clr = put_bit(err_clr, `RDI_BIT_E_COLL, rx_startup);
        err_clr = put_bit(err_clr, `RDI_BIT_E_CRC, rx_startup);
        err_clr = put_bit(err_clr, `RDI_BIT_E_PAR, rx_startup);
        err_clr = put_bit(err_clr, `RDI_BIT_E_SOF, rx_startup);
        // Set wins over an automatic clear in the same cycle
        err_next_v = (st_r.err & ~err_clr) | err_set;
    end

    // ************************************************************
    // Hardware request events
    // ************************************************************
    always_comb begin
        comm_hw = `RDI_RST_BYTE;
        aux_hw  = `RDI_RST_BYTE;
        comm_hw = put_bit(comm_hw, `RDI_BIT_TX, tx_last_bit_sent);
        comm_hw = put_bit(comm_hw, `RDI_BIT_RX,
                          rx_data_valid & rx_require_no_error);
        comm_hw = put_bit(comm_hw, `RDI_BIT_IDLE,
                          cmd_terminated | cmd_unknown_started);
        comm_hw = put_bit(comm_hw, `RDI_BIT_HI, ev.hi_rise);
        comm_hw = put_bit(comm_hw, `RDI_BIT_LO, ev.lo_rise);
        comm_hw = put_bit(comm_hw, `RDI_BIT_ERRF,
                          |(err_next_v & ~st_r.err));
        comm_hw = put_bit(comm_hw, `RDI_BIT_TIMER, ev.timer_zero);
        aux_hw  = put_bit(aux_hw, `RDI_BIT_CARD, lpcd_card_detected);
        aux_hw  = put_bit(aux_hw, `RDI_BIT_TEST, ev.test_edge);
        aux_hw  = put_bit(aux_hw, `RDI_BIT_CRCD,
                          crc_cmd_valid & crc_all_done);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        if (hit_comm_en) begin
            st_nxt.comm_en = reg_wdata & `RDI_MASK_COMM_EN;
        end
        if (hit_aux_en) begin
            st_nxt.aux_en = reg_wdata & `RDI_MASK_AUX_EN;
        end
        // Hardware set wins over a software clear in the same cycle
        st_nxt.comm_req = sc_write(st_r.comm_req, reg_wdata,
                                   `RDI_MASK_COMM_REQ, hit_comm_req)
                        | comm_hw;
        st_nxt.aux_req  = sc_write(st_r.aux_req, reg_wdata,
                                   `RDI_MASK_AUX_REQ, hit_aux_req)
                        | aux_hw;
        st_nxt.err       = err_next_v;
        st_nxt.cmd_clear = cmd_unknown_started;
        st_nxt.rdata     = `RDI_RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `RDI_ADDR_COMM_EN:  st_nxt.rdata = st_r.comm_en;
                `RDI_ADDR_AUX_EN:   st_nxt.rdata = st_r.aux_en;
                `RDI_ADDR_COMM_REQ: st_nxt.rdata = st_r.comm_req;
                `RDI_ADDR_AUX_REQ:  st_nxt.rdata = st_r.aux_req;
                `RDI_ADDR_ERR:      st_nxt.rdata = st_r.err;
                default:            st_nxt.rdata = `RDI_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_r <= '{comm_en: `RDI_RST_COMM_EN, aux_en: `RDI_RST_AUX_EN,
                      comm_req: `RDI_RST_COMM_REQ,
                      aux_req: `RDI_RST_AUX_REQ, err: `RDI_RST_ERR,
                      rdata: `RDI_RST_BYTE, cmd_clear: `RDI_RST_BIT};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs and IRQ pin
    // ************************************************************
    assign irq_status = |(st_r.comm_req & st_r.comm_en & `RDI_MASK_COMM_REQ)
                      | |(st_r.aux_req & st_r.aux_en & `RDI_MASK_AUX_REQ);
    assign pin_level  = irq_status ^ st_r.comm_en[`RDI_BIT_INVERT];
    // Open drain only pulls low; push-pull drives both levels
    assign irq_out    = st_r.aux_en[`RDI_BIT_DRIVE] & pin_level;
    assign irq_oe     = st_r.aux_en[`RDI_BIT_DRIVE] | ~pin_level;
    assign reg_rdata       = st_r.rdata;
    assign cmd_field_clear = st_r.cmd_clear;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_comm_set_wr;
        hit_comm_req && reg_wdata[`RDI_BIT_SETSEL];
    endsequence

    sequence s_comm_clr_wr;
        hit_comm_req && !reg_wdata[`RDI_BIT_SETSEL] && (comm_hw == 8'h00);
    endsequence

    sequence s_tx_then_quiet;
        tx_last_bit_sent ##1 !hit_comm_req;
    endsequence

    sequence s_timer_reach_zero;
        (timer_current_value != `RDI_TIMER_ZERO) ##1
        (timer_current_value == `RDI_TIMER_ZERO);
    endsequence

    a_irq_reset_hiz: assert property (
        $rose(nrst) |-> !irq_oe && !irq_status)
        else $error("IRQ pin driven right after reset");

    a_comm_gate: assert property (
        ((st_r.comm_en & `RDI_MASK_COMM_REQ) == 8'h00 &&
         (st_r.aux_en & `RDI_MASK_AUX_REQ) == 8'h00)
        |-> !irq_status)
        else $error("IRQ status raised with every enable off");

    a_aux_card_gate: assert property (
        (st_r.aux_en[`RDI_BIT_CARD] && lpcd_card_detected) |=> irq_status)
        else $error("Enabled card detect did not raise IRQ status");

    a_set_write: assert property (
        s_comm_set_wr |=>
        ((st_r.comm_req & $past(reg_wdata) & `RDI_MASK_COMM_REQ) ==
         ($past(reg_wdata) & `RDI_MASK_COMM_REQ)))
        else $error("Set write did not set written flags");

    a_clear_write: assert property (
        s_comm_clr_wr |=>
        ((st_r.comm_req & $past(reg_wdata) & `RDI_MASK_COMM_REQ) == 8'h00))
        else $error("Clear write left written flags set");

    a_tx_sticky: assert property (
        s_tx_then_quiet |=> st_r.comm_req[`RDI_BIT_TX])
        else $error("Transmit done flag not set or not held");

    a_idle_cmd_quiet: assert property (
        (cmd_idle_started && !cmd_terminated && !cmd_unknown_started &&
         !st_r.comm_req[`RDI_BIT_IDLE] && !hit_comm_req)
        |=> !st_r.comm_req[`RDI_BIT_IDLE])
        else $error("Idle command start set the idle flag");

    a_err_flag_rise: assert property (
        (st_r.err == 8'h00) ##1 (st_r.err != 8'h00)
        |-> st_r.comm_req[`RDI_BIT_ERRF])
        else $error("Error flag missed a new error bit");

    a_timer_zero: assert property (
        s_timer_reach_zero |=> st_r.comm_req[`RDI_BIT_TIMER])
        else $error("Timer flag not set at zero");

    a_test_edge: assert property (
        $changed(test_signal_input) |=> st_r.aux_req[`RDI_BIT_TEST])
        else $error("Test input edge did not set its flag");

    a_crc_err_clear: assert property (
        (rx_startup && !(crc_mismatch && rx_crc_check_enable))
        |=> !st_r.err[`RDI_BIT_E_CRC])
        else $error("CRC error not cleared at receiver start");

    a_pin_polarity: assert property (
        (st_r.aux_en[`RDI_BIT_DRIVE] && $stable(st_r.comm_en))
        |-> irq_oe && (irq_out == (irq_status ^
                        st_r.comm_en[`RDI_BIT_INVERT])))
        else $error("Push-pull IRQ pin level wrong for polarity");

    a_rx_gate: assert property (
        (rx_data_valid && !rx_require_no_error && !hit_comm_req &&
         !st_r.comm_req[`RDI_BIT_RX]) |=> !st_r.comm_req[`RDI_BIT_RX])
        else $error("Receive flag set with no-error option off");

    a_fifo_high_rise: assert property (
        $rose(fifo_high_status) |=> st_r.comm_req[`RDI_BIT_HI])
        else $error("FIFO high alert rise did not set its flag");

    a_fifo_low_rise: assert property (
        $rose(fifo_low_status) |=> st_r.comm_req[`RDI_BIT_LO])
        else $error("FIFO low alert rise did not set its flag");

    a_field_clear: assert property (
        cmd_unknown_started |=>
        cmd_field_clear && st_r.comm_req[`RDI_BIT_IDLE])
        else $error("Unknown command did not clear field or set idle");

    a_crc_done_gate: assert property (
        (crc_all_done && !crc_cmd_valid && !hit_aux_req &&
         !st_r.aux_req[`RDI_BIT_CRCD]) |=> !st_r.aux_req[`RDI_BIT_CRCD])
        else $error("CRC flag set without a valid CRC command");

    a_err_read_only: assert property (
        (reg_wr && reg_addr == `RDI_ADDR_ERR && err_set == 8'h00 &&
         err_clr == 8'h00) |=> $stable(st_r.err))
        else $error("Host write changed the error register");

endmodule

// [rdi_host_model.sv]
module rdi_host_model (
    input  wire logic       clock,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       irq_out,
    input  wire logic       irq_oe,
    output logic            irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Pull-up on the board side of the interrupt line
    // ************************************************************
    assign irq_pin = irq_oe ? irq_out : 1'b1;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // ************************************************************
    // Register bus cycles
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule

// [rdi_irq_flags_tb.sv]
module rdi_irq_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic        clock = 1'b0;
    logic        nrst  = 1'b0;
    logic [17:0] ev    = '0;
    logic [15:0] timer_current_value = 16'h0000;
    logic        rx_require_no_error = 1'b1;
    logic        rx_crc_check_enable = 1'b1;
    logic        fifo_high_status    = 1'b0;
    logic        fifo_low_status     = 1'b0;
    logic        test_signal_input   = 1'b0;
    logic        crc_cmd_valid       = 1'b1;
    logic        rate_106k           = 1'b1;
    logic        type_a_mode         = 1'b1;
    logic        fifo_flush, temp_clear, fifo_overflow, over_temp;
    logic        write_fault, collision_fault, cmd_start, rx_startup;
    logic        sof_fault, parity_fault, crc_mismatch, crc_all_done;
    logic        lpcd_card_detected, cmd_idle_started;
    logic        cmd_unknown_started, cmd_terminated;
    logic        rx_data_valid, tx_last_bit_sent;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, irq_out, irq_oe, irq_pin;
    logic        irq_status, cmd_field_clear;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;

    assign {fifo_flush, temp_clear, fifo_overflow, over_temp, write_fault,
            collision_fault, cmd_start, rx_startup, sof_fault, parity_fault,
            crc_mismatch, crc_all_done, lpcd_card_detected, cmd_idle_started,
            cmd_unknown_started, cmd_terminated, rx_data_valid,
            tx_last_bit_sent} = ev;

    always #5 clock = ~clock;

    rdi_irq_flags #(.TW(16)) u_dut (
        .clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .tx_last_bit_sent, .rx_data_valid, .rx_require_no_error,
        .cmd_terminated, .cmd_unknown_started, .cmd_idle_started, .cmd_start,
        .fifo_high_status, .fifo_low_status, .timer_current_value,
        .lpcd_card_detected, .test_signal_input, .crc_cmd_valid,
        .crc_all_done, .rx_startup, .rx_crc_check_enable, .crc_mismatch,
        .parity_fault, .sof_fault, .collision_fault, .rate_106k,
        .type_a_mode, .write_fault, .over_temp, .temp_clear, .fifo_overflow,
        .fifo_flush, .irq_out, .irq_oe, .irq_status, .cmd_field_clear
    );

    rdi_host_model u_host (
        .clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq_out, .irq_oe, .irq_pin
    );

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        chk($sformatf("register %h", a), e, d);
    endtask

    task automatic st(input logic e);
        @(negedge clock);
        chk("irq status", {7'h00, e}, {7'h00, irq_status});
    endtask

    // Expected status, output enable, resolved pin level
    task automatic pin(input logic [2:0] e);
        @(negedge clock);
        chk("irq pin", {5'h00, e}, {5'h00, irq_status, irq_oe, irq_pin});
    endtask

    task automatic fire(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev <= '0;
        @(negedge clock);
    endtask

    task automatic clr();
        u_host.wr(8'h04, 8'h7F);
        u_host.wr(8'h05, 8'h34);
    endtask

    task automatic gate(input logic [7:0] rq, input logic [7:0] en,
                        input logic [7:0] b, input logic [7:0] all);
        u_host.wr(rq, 8'h80 | b);
        u_host.wr(en, all & ~b);
        st(1'b0);
        u_host.wr(en, b);
        st(1'b1);
        u_host.wr(rq, b);
        st(1'b0);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        pin(3'b001);
        rdc(8'h02, 8'h80);
        rdc(8'h03, 8'h00);
        rdc(8'h04, 8'h14);
        rdc(8'h05, 8'h00);
        rdc(8'h06, 8'h00);
        rdc(8'h07, 8'h00);
    endtask

    task automatic t_setclr();
        u_host.wr(8'h04, 8'hC1);
        rdc(8'h04, 8'h55);
        u_host.wr(8'h04, 8'h7F);
        rdc(8'h04, 8'h00);
        u_host.wr(8'h05, 8'hFF);
        rdc(8'h05, 8'h34);
        u_host.wr(8'h05, 8'h34);
        rdc(8'h05, 8'h00);
        u_host.wr(8'h06, 8'hFF);
        rdc(8'h06, 8'h00);
    endtask

    task automatic t_gate();
        int ab[3] = '{5, 4, 2};
        for (int i = 0; i < 7; i++) begin
            gate(8'h04, 8'h02, 8'h01 << i, 8'hFF);
        end
        foreach (ab[k]) begin
            gate(8'h05, 8'h03, 8'h01 << ab[k], 8'h34);
        end
        u_host.wr(8'h03, 8'hFF);
        rdc(8'h03, 8'hB4);
    endtask

    task automatic t_events();
        logic [7:0] ad[7] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h05,
                              8'h05};
        logic [7:0] ex[7] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h00, 8'h20,
                              8'h04};
        logic [7:0] ee[7] = '{8'h04, 8'h02, 8'h01, 8'h08, 8'h80, 8'h40,
                              8'h10};
        int         es[7] = '{7, 8, 9, 12, 13, 14, 15};
        int         ec[7] = '{10, 10, 10, 10, 11, 16, 17};
        for (int i = 0; i < 7; i++) begin
            clr();
            fire(i);
            if (i == 3) begin
                chk("field clear", 8'h01, 8'(cmd_field_clear));
            end
            rdc(ad[i], ex[i]);
        end
        for (int j = 0; j < 7; j++) begin
            clr();
            fire(es[j]);
            rdc(8'h04, 8'h02);
            rdc(8'h06, ee[j]);
            fire(ec[j]);
            rdc(8'h06, 8'h00);
        end
        @(posedge clock);
        rx_crc_check_enable <= 1'b0;
        rx_require_no_error <= 1'b0;
        crc_cmd_valid       <= 1'b0;
        type_a_mode         <= 1'b0;
        clr();
        fire(1);
        fire(6);
        fire(7);
        fire(8);
        rdc(8'h04, 8'h00);
        rdc(8'h05, 8'h00);
        rdc(8'h06, 8'h00);
        @(posedge clock);
        rate_106k <= 1'b0;
        fire(9);
        fire(12);
        rdc(8'h06, 8'h00);
    endtask

    task automatic t_levels();
        clr();
        @(posedge clock);
        fifo_high_status    <= 1'b1;
        fifo_low_status     <= 1'b1;
        test_signal_input   <= 1'b1;
        timer_current_value <= 16'h0001;
        @(posedge clock);
        timer_current_value <= 16'h0000;
        rdc(8'h04, 8'h0D);
        rdc(8'h05, 8'h10);
        clr();
        rdc(8'h04, 8'h00);
        @(posedge clock);
        test_signal_input <= 1'b0;
        rdc(8'h05, 8'h10);
    endtask

    task automatic t_pin();
        clr();
        fire(0);
        u_host.wr(8'h02, 8'h40);
        u_host.wr(8'h03, 8'h80);
        pin(3'b111);
        u_host.wr(8'h02, 8'hC0);
        pin(3'b110);
        u_host.wr(8'h03, 8'h00);
        pin(3'b110);
        u_host.wr(8'h02, 8'h40);
        pin(3'b101);
    endtask

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        t_reset();
        t_setclr();
        t_gate();
        t_events();
        t_levels();
        t_pin();
        wrap_up();
    end
endmodule
